// ===== src/fifo_read_pkg.sv
// constants shared by the read-side fifo control block
package fifo_read_pkg;
  localparam int unsigned DATA_W   = 72;   // widest read word
  localparam int unsigned OFS_W    = 18;   // flag offset register width
  localparam int unsigned SHIFT_W  = 2 * OFS_W;
  localparam int unsigned SUB_W    = 2;    // slice index width
  localparam int unsigned DEPTH    = 16384;
  // default offsets loaded by master reset
  localparam logic [OFS_W-1:0] EMPTY_OFS_RESET = 18'h0_007F;
  localparam logic [OFS_W-1:0] FULL_OFS_RESET  = 18'h0_007F;
  localparam logic [DATA_W-1:0] DATA_RESET     = 72'h00_0000_0000_0000_0000;
  localparam logic [5:0] SHIFT_LAST = 6'h23;  // index of final serial bit
  localparam logic [5:0] SHIFT_ZERO = 6'h00;
  // read bus width selection
  typedef enum logic [1:0] {
    OUT_X72,
    OUT_X36,
    OUT_X18
  } out_width_e;
endpackage

// ===== src/offset_link_if.sv
// carries a completed serial offset word from the serial clock domain
interface offset_link_if;
  import fifo_read_pkg::*;
  logic [SHIFT_W-1:0] word;    // {empty offset, full offset}, stable between loads
  logic               toggle;  // flips once per completed load
  modport loader (output word, output toggle);
  modport core   (input word, input toggle);
endinterface

// ===== src/serial_offset_loader.sv
// serial offset shift register running on the serial programming clock
module serial_offset_loader
  import fifo_read_pkg::*;
(
  input  wire logic   serialClock,
  input  wire logic   rstn,
  input  wire logic   serialIn,
  input  wire logic   serial_load_enable_n,
  offset_link_if.loader link
);
  logic               rstSync1Reg;
  logic               rstSync2Reg;
  logic               dinSync1Reg;
  logic               dinSync2Reg;
  logic               enSync1Reg;
  logic               enSync2Reg;
  logic [SHIFT_W-1:0] shiftReg;
  logic [5:0]         bitCountReg;
  logic [SHIFT_W-1:0] wordReg;
  logic               toggleReg;

  // pins and reset resynchronised to the serial clock
  always_ff @(posedge serialClock) begin
    rstSync1Reg <= rstn;
    rstSync2Reg <= rstSync1Reg;
    dinSync1Reg <= serialIn;
    dinSync2Reg <= dinSync1Reg;
    enSync1Reg  <= serial_load_enable_n;
    enSync2Reg  <= enSync1Reg;
  end

  // shift one bit per enabled edge, msb first
  always_ff @(posedge serialClock) begin
    if (!rstSync2Reg) begin
      shiftReg    <= '0;
      bitCountReg <= SHIFT_ZERO;
    end else if (!enSync2Reg) begin
      shiftReg <= {shiftReg[SHIFT_W-2:0], dinSync2Reg};
      bitCountReg <= (bitCountReg == SHIFT_LAST) ? SHIFT_ZERO : bitCountReg + 6'h01;
    end
  end

  // publish the word once all bits are in and flip the toggle on the same edge
  always_ff @(posedge serialClock) begin
    if (!rstSync2Reg) begin
      wordReg   <= {EMPTY_OFS_RESET, FULL_OFS_RESET};
      toggleReg <= 1'b0;
    end else if (!enSync2Reg && bitCountReg == SHIFT_LAST) begin
      wordReg   <= {shiftReg[SHIFT_W-2:0], dinSync2Reg};
      toggleReg <= ~toggleReg;
    end
  end

  assign link.word   = wordReg;
  assign link.toggle = toggleReg;
endmodule

// ===== src/fifo_read_port_flag_logic.sv
// read-side control of a deep fifo: flags, resets, read port, retransmit
module fifo_read_port_flag_logic
  import fifo_read_pkg::*;
#(
  parameter int unsigned MEM_DEPTH = DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              serialClock,
  input  wire logic              master_reset_n,
  input  wire logic              partial_reset_n,
  input  wire logic              flag_timing_select,
  input  wire logic              fall_through_mode,
  input  wire logic              readStrobeMode,
  input  wire logic [1:0]        outWidthSelect,
  input  wire logic              readClock,
  input  wire logic              readEnableN,
  input  wire logic              read_chip_select_n,
  input  wire logic              outputEnableN,
  input  wire logic              offset_load_n,
  input  wire logic              retransmit_n,
  input  wire logic              markIn,
  input  wire logic              serial_load_enable_n,
  input  wire logic              writeEnable,
  input  wire logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0]      read_data_out,
  output logic                   readDataOutEnable,
  output logic                   empty_flag_n,
  output logic                   almost_empty_flag,
  output logic                   almost_full_flag
);
  localparam int unsigned PTR_W = $clog2(MEM_DEPTH);

  // two-stage synchronisers for ten control pins; readStrobeMode and outWidthSelect are used unsynchronised
  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] pinSync1Reg;
  logic [NSYNC-1:0] pinSync2Reg;
  logic             readClockDlyReg;
  logic             mrsActive;
  logic             prsActive;
  logic             resetActive;
  logic             readClockSync;
  logic             renSync;
  logic             csActive;
  logic             oeActive;
  logic             ldSync;
  logic             rtActive;
  logic             markSync;
  logic             fwftSync;
  logic             pfmSync;
  logic             readEdge;
  logic             readEvent;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pinSync1Reg     <= 10'h3_FF;
      pinSync2Reg     <= 10'h3_FF;
      readClockDlyReg <= 1'b1;  // matches the synchroniser's reset level, no false edge
    end else begin
      pinSync1Reg <= {master_reset_n, partial_reset_n, readClock, readEnableN,
                      read_chip_select_n, outputEnableN, offset_load_n, retransmit_n,
                      ~markIn, fall_through_mode};
      pinSync2Reg     <= pinSync1Reg;
      readClockDlyReg <= pinSync2Reg[7];
    end
  end

  assign mrsActive     = !pinSync2Reg[9];
  assign prsActive     = !pinSync2Reg[8];
  assign resetActive   = mrsActive || prsActive;
  assign readClockSync = pinSync2Reg[7];
  assign renSync       = !pinSync2Reg[6];
  assign csActive      = !pinSync2Reg[5];
  assign oeActive      = !pinSync2Reg[4];
  assign ldSync        = pinSync2Reg[3];
  assign rtActive      = !pinSync2Reg[2];
  assign markSync      = !pinSync2Reg[1];
  assign fwftSync      = pinSync2Reg[0];

  // flag timing select is a quasi-static strap; two flops as well
  logic pfmSync1Reg;
  logic pfmSync2Reg;
  always_ff @(posedge clock) begin
    pfmSync1Reg <= flag_timing_select;
    pfmSync2Reg <= pfmSync1Reg;
  end
  assign pfmSync = pfmSync2Reg;

  // rising read-clock edge, gated by chip select outside reset
  assign readEdge  = readClockSync && !readClockDlyReg && !resetActive && csActive;
  assign readEvent = readEdge && (readStrobeMode || renSync);

  // configuration captured while master reset is held
  logic       syncFlagsReg;
  logic       fwftReg;
  logic       strobeReg;
  out_width_e widthReg;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncFlagsReg <= 1'b0;
      fwftReg      <= 1'b0;
      widthReg     <= OUT_X72;
    end else if (mrsActive) begin
      syncFlagsReg <= pfmSync;
      fwftReg      <= fwftSync;
      widthReg     <= out_width_e'(outWidthSelect);
    end
  end

  // serial offset loading lives on the serial clock
  offset_link_if link ();
  serial_offset_loader loader (
    .serialClock          (serialClock),
    .rstn                 (rstn),
    .serialIn             (fall_through_mode),
    .serial_load_enable_n (serial_load_enable_n),
    .link                 (link)
  );

  // toggle crossing, word is stable long before the toggle lands
  logic             tglSync1Reg;
  logic             tglSync2Reg;
  logic             tglSync3Reg;
  logic [OFS_W-1:0] emptyOfsReg;
  logic [OFS_W-1:0] fullOfsReg;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tglSync1Reg <= 1'b0;
      tglSync2Reg <= 1'b0;
      tglSync3Reg <= 1'b0;
    end else begin
      tglSync1Reg <= link.toggle;
      tglSync2Reg <= tglSync1Reg;
      tglSync3Reg <= tglSync2Reg;
    end
  end

  // offsets: defaults on master reset, kept across partial reset
  always_ff @(posedge clock) begin
    if (!rstn || mrsActive) begin
      emptyOfsReg <= EMPTY_OFS_RESET;
      fullOfsReg  <= FULL_OFS_RESET;
    end else if (tglSync2Reg != tglSync3Reg) begin
      emptyOfsReg <= link.word[SHIFT_W-1:OFS_W];
      fullOfsReg  <= link.word[OFS_W-1:0];
    end
  end

  // storage array and pointers
  logic [DATA_W-1:0] memArray [MEM_DEPTH];
  logic [PTR_W:0]    wrPtrReg;
  logic [PTR_W:0]    rdPtrReg;
  logic [PTR_W:0]    markPtrReg;
  logic              markValidReg;
  logic [PTR_W:0]    fillCount;
  logic [PTR_W:0]    freeCount;
  logic              notEmpty;
  logic              writeOk;
  assign fillCount = wrPtrReg - rdPtrReg;
  assign freeCount = (PTR_W + 1)'(MEM_DEPTH) - fillCount;
  assign notEmpty  = fillCount != '0;
  assign writeOk   = writeEnable && freeCount != '0 && !resetActive;

  always_ff @(posedge clock) begin
    if (writeOk) begin
      memArray[wrPtrReg[PTR_W-1:0]] <= writeData;
    end
  end

  // write pointer, cleared by resets, advanced only by accepted writes
  always_ff @(posedge clock) begin
    if (!rstn || resetActive) begin
      wrPtrReg <= '0;
    end else if (writeOk) begin
      wrPtrReg <= wrPtrReg + 1'b1;
    end
  end

  // slice selection for narrow read buses
  function automatic logic [DATA_W-1:0] sliceOf(input logic [DATA_W-1:0] w,
                                                 input out_width_e sel,
                                                 input logic [SUB_W-1:0] idx);
    logic [DATA_W-1:0] r;
    r = '0;
    if (sel == OUT_X36) begin
      r[35:0] = idx[0] ? w[71:36] : w[35:0];
    end else if (sel == OUT_X18) begin
      r[17:0] = w[18*idx +: 18];
    end else begin
      r = w;
    end
    return r;
  endfunction

  function automatic logic [SUB_W-1:0] lastSub(input out_width_e sel);
    logic [SUB_W-1:0] r;
    r = (sel == OUT_X36) ? 2'h1 : (sel == OUT_X18) ? 2'h3 : 2'h0;
    return r;
  endfunction

  // read side state
  logic              memRead;
  logic              subRead;
  logic              ofsRead;
  logic              rtEvent;
  logic              markEvent;
  logic [SUB_W-1:0]  subReg;
  logic [DATA_W-1:0] holdReg;
  logic              outValidReg;
  logic              ofsSelReg;
  logic              rtForceReg;
  logic [DATA_W-1:0] memWord;
  assign memWord   = memArray[rdPtrReg[PTR_W-1:0]];
  assign rtEvent   = readEdge && rtActive;
  assign markEvent = readEdge && markSync && !rtActive;
  assign ofsRead   = readEvent && !ldSync && !rtEvent;
  assign subRead   = readEvent && ldSync && !rtEvent && subReg != '0;
  // standard: load on an explicit read; fall-through: refill whenever free
  assign memRead = !resetActive && !rtEvent && notEmpty && ldSync &&
                   (fwftReg ? (!outValidReg || (readEvent && subReg == lastSub(widthReg)))
                            : (readEvent && subReg == '0));

  // read pointer, mark and retransmit
  always_ff @(posedge clock) begin
    if (!rstn || resetActive) begin
      rdPtrReg     <= '0;
      markPtrReg   <= '0;
      markValidReg <= 1'b0;
    end else if (rtEvent) begin
      rdPtrReg <= markValidReg ? markPtrReg : '0;
    end else begin
      if (memRead) begin
        rdPtrReg <= rdPtrReg + 1'b1;
      end
      if (markEvent) begin
        markPtrReg   <= rdPtrReg;
        markValidReg <= 1'b1;
      end
    end
  end

  // output register, slice index and offset readback pointer
  always_ff @(posedge clock) begin
    if (!rstn || resetActive) begin
      read_data_out <= DATA_RESET;
      holdReg       <= DATA_RESET;
      subReg        <= '0;
      outValidReg   <= 1'b0;
      ofsSelReg     <= 1'b0;
    end else if (rtEvent) begin
      subReg      <= '0;
      outValidReg <= 1'b0;
    end else if (ofsRead) begin
      read_data_out <= {{(DATA_W-OFS_W){1'b0}}, ofsSelReg ? fullOfsReg : emptyOfsReg};
      ofsSelReg     <= ~ofsSelReg;
    end else if (memRead) begin
      holdReg       <= memWord;
      read_data_out <= sliceOf(memWord, widthReg, '0);
      subReg        <= (lastSub(widthReg) == '0) ? '0 : 2'h1;
      outValidReg   <= 1'b1;
    end else if (subRead) begin
      read_data_out <= sliceOf(holdReg, widthReg, subReg);
      subReg        <= (subReg == lastSub(widthReg)) ? '0 : subReg + 2'h1;
    end else if (fwftReg && readEvent && ldSync && !notEmpty && subReg == lastSub(widthReg)) begin
      outValidReg <= 1'b0;
      subReg      <= '0;
    end
  end

  // retransmit forces empty_flag_n low in standard mode and high (output ready) in fall-through mode until the next read-clock edge
  always_ff @(posedge clock) begin
    if (!rstn || resetActive) begin
      rtForceReg <= 1'b0;
    end else if (rtEvent) begin
      rtForceReg <= 1'b1;
    end else if (readEdge) begin
      rtForceReg <= 1'b0;
    end
  end

  // empty flag in standard mode, output ready in fall-through mode
  always_comb begin
    if (fwftReg) begin
      empty_flag_n = outValidReg || rtForceReg;
    end else begin
      empty_flag_n = notEmpty && !rtForceReg;
    end
  end

  // programmable flags, level compares against the offsets
  logic aeLevel;
  logic afLevel;
  logic aeSyncReg;
  logic afSyncReg;
  assign aeLevel = OFS_W'(fillCount) >= emptyOfsReg;
  assign afLevel = OFS_W'(freeCount) > fullOfsReg;

  // sync timing: empty side on read edges, full side on write cycles
  always_ff @(posedge clock) begin
    if (!rstn || resetActive) begin
      aeSyncReg <= 1'b0;
      afSyncReg <= 1'b1;
    end else begin
      if (readEdge) begin
        aeSyncReg <= aeLevel;
      end
      if (writeEnable) begin
        afSyncReg <= afLevel;
      end
    end
  end

  assign almost_empty_flag = syncFlagsReg ? aeSyncReg : aeLevel;
  assign almost_full_flag  = syncFlagsReg ? afSyncReg : afLevel;

  // output drive: output enable alone decides during resets
  assign readDataOutEnable = oeActive && (resetActive || csActive);

  AST_AE_LOW: assert property (@(posedge clock) disable iff (!rstn)
    (!syncFlagsReg && OFS_W'(fillCount) < emptyOfsReg) |-> !almost_empty_flag)
    else $error("almost-empty not low below offset");
  AST_AE_HIGH: assert property (@(posedge clock) disable iff (!rstn)
    (!syncFlagsReg && OFS_W'(fillCount) >= emptyOfsReg) |-> almost_empty_flag)
    else $error("almost-empty not high at offset");
  AST_AF_HIGH: assert property (@(posedge clock) disable iff (!rstn)
    (!syncFlagsReg && OFS_W'(freeCount) > fullOfsReg) |-> almost_full_flag)
    else $error("almost-full not high above offset");
  AST_AF_LOW: assert property (@(posedge clock) disable iff (!rstn)
    (!syncFlagsReg && OFS_W'(freeCount) <= fullOfsReg) |-> !almost_full_flag)
    else $error("almost-full not low at offset");
  AST_PFM_CAPTURE: assert property (@(posedge clock) disable iff (!rstn)
    mrsActive |=> syncFlagsReg == $past(pfmSync))
    else $error("flag timing not captured in master reset");
  AST_PRS_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
    prsActive |=> rdPtrReg == '0 && wrPtrReg == '0 && read_data_out == DATA_RESET)
    else $error("partial reset left state behind");
  AST_PRS_KEEP: assert property (@(posedge clock) disable iff (!rstn)
    (prsActive && !mrsActive && tglSync2Reg == tglSync3Reg) |=>
      $stable(emptyOfsReg) && $stable(fullOfsReg) && $stable(fwftReg))
    else $error("partial reset disturbed settings");
  AST_RT_TARGET: assert property (@(posedge clock) disable iff (!rstn)
    rtEvent |=> rdPtrReg == ($past(markValidReg) ? $past(markPtrReg) : '0))
    else $error("retransmit landed on wrong location");
  AST_RT_HOLD_WR: assert property (@(posedge clock) disable iff (!rstn)
    (rtEvent && !writeOk) |=> $stable(wrPtrReg) && $stable(emptyOfsReg))
    else $error("retransmit moved write state");
  AST_CS_GATE: assert property (@(posedge clock) disable iff (!rstn)
    (!resetActive && !csActive) |-> !readDataOutEnable && !readEvent)
    else $error("deselected port still active");
  AST_RESET_DRIVE: assert property (@(posedge clock) disable iff (!rstn)
    (resetActive && oeActive) |-> readDataOutEnable)
    else $error("reset output drive ignored output enable");
  AST_OFS_READ: assert property (@(posedge clock) disable iff (!rstn)
    ofsRead |=> read_data_out[OFS_W-1:0] == ($past(ofsSelReg) ? $past(fullOfsReg) : $past(emptyOfsReg)))
    else $error("offset readback wrong");
endmodule

// ===== bench/read_controller_model.sv
// reading controller model: read clock pulses and serial offset frames
module read_controller_model (
  input  wire logic clock,
  output logic      readClock,
  output logic      serialClock,
  output logic      serialData,
  output logic      serial_load_enable_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels: clocks still, serial enable off
  initial begin
    readClock = 1'b0;
    serialClock = 1'b0;
    serialData = 1'b0;
    serial_load_enable_n = 1'b1;
  end

  // a few serial clocks with enable off, so the loader sees reset
  task automatic serial_idle();
    repeat (4) begin
      #16 serialClock = 1'b1;
      #16 serialClock = 1'b0;
    end
  endtask

  // one read-clock rise, high and low for four system clocks each
  task automatic read_pulse();
    @(negedge clock);
    readClock = 1'b1;
    repeat (4) @(negedge clock);
    readClock = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // msb-first frame of 36 bits, then two flush edges for the synchroniser
  task automatic load_serial(input logic [35:0] bits);
    #3;
    serial_load_enable_n = 1'b0;
    for (int i = 35; i >= 0; i--) begin
      serialData = bits[i];
      #16 serialClock = 1'b1;
      #16 serialClock = 1'b0;
    end
    serial_load_enable_n = 1'b1;
    serialData = ~bits[0]; // released line shows no stale bit
    repeat (2) begin
      #16 serialClock = 1'b1;
      #16 serialClock = 1'b0;
    end
  endtask
endmodule

// ===== bench/test_fifo_read_port_flag_logic.sv
// self-checking bench for the fifo read-side control block
module test_fifo_read_port_flag_logic;
  import fifo_read_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEP = 64;

  logic              clock, rstn, master_reset_n, partial_reset_n, flag_timing_select;
  logic              fall_through_mode, readStrobeMode, readClock, readEnableN, serialClock;
  logic              read_chip_select_n, outputEnableN, offset_load_n, retransmit_n, markIn;
  logic              serial_load_enable_n, writeEnable, readDataOutEnable, empty_flag_n;
  logic              almost_empty_flag, almost_full_flag;
  logic [1:0]        outWidthSelect;
  logic [DATA_W-1:0] writeData, read_data_out, lastOut, w;
  logic [DATA_W-1:0] mem [DEP];
  int                wrP, rdP, markP, eOfs, fOfs, n_fail, num_checks;

  fifo_read_port_flag_logic #(.MEM_DEPTH(DEP)) fifo_read_port_flag_logic_inst (
    .clock(clock), .rstn(rstn), .serialClock(serialClock), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .flag_timing_select(flag_timing_select),
    .fall_through_mode(fall_through_mode), .readStrobeMode(readStrobeMode),
    .outWidthSelect(outWidthSelect), .readClock(readClock), .readEnableN(readEnableN),
    .read_chip_select_n(read_chip_select_n), .outputEnableN(outputEnableN),
    .offset_load_n(offset_load_n), .retransmit_n(retransmit_n), .markIn(markIn),
    .serial_load_enable_n(serial_load_enable_n), .writeEnable(writeEnable), .writeData(writeData),
    .read_data_out(read_data_out), .readDataOutEnable(readDataOutEnable),
    .empty_flag_n(empty_flag_n), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag)
  );

  read_controller_model read_controller_model_inst (
    .clock(clock), .readClock(readClock), .serialClock(serialClock),
    .serialData(fall_through_mode), .serial_load_enable_n(serial_load_enable_n)
  );

  // system clock
  always #4 clock = ~clock;

  // one comparison, counted and reported
  task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // flag outputs against the model's fill level
  task automatic chkFlags();
    chk("emptyFlagN", empty_flag_n, (wrP - rdP) != 0);
    chk("almostEmpty", almost_empty_flag, (wrP - rdP) >= eOfs);
    chk("almostFull", almost_full_flag, (DEP - (wrP - rdP)) > fOfs);
  endtask

  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$urandom(), $urandom(), $urandom()});
  endfunction

  // master reset with straps, model back to defaults
  task automatic mreset(input logic sync, input logic [1:0] width);
    @(negedge clock);
    master_reset_n = 1'b0;
    flag_timing_select = sync;
    outWidthSelect = width;
    read_controller_model_inst.serialData = 1'b0;
    repeat (6) @(negedge clock);
    master_reset_n = 1'b1;
    repeat (6) @(negedge clock);
    wrP = 0;
    rdP = 0;
    markP = 0;
    eOfs = 'h7F;
    fOfs = 'h7F;
    lastOut = '0;
  endtask

  // one write cycle; refused when full
  task automatic wr(input logic [DATA_W-1:0] d);
    @(negedge clock);
    writeEnable = 1'b1;
    writeData = d;
    @(negedge clock);
    writeEnable = 1'b0;
    if (wrP - rdP < DEP) begin
      mem[wrP % DEP] = d;
      wrP++;
    end
    repeat (3) @(negedge clock);
    chkFlags();
  endtask

  // one read; empty reads leave the output alone
  task automatic rd();
    read_controller_model_inst.read_pulse();
    if (wrP > rdP) begin
      lastOut = mem[rdP % DEP];
      rdP++;
    end
    chk("readData", read_data_out, lastOut);
    chkFlags();
  endtask

  // read edge carrying mark or retransmit, enable off
  task automatic ctlPulse(input logic mk, input logic rt);
    readEnableN = 1'b1;
    markIn = mk;
    retransmit_n = ~rt;
    read_controller_model_inst.read_pulse();
    markIn = 1'b0;
    retransmit_n = 1'b1;
    readEnableN = 1'b0;
    if (mk) markP = rdP;
    if (rt) begin
      rdP = markP;
      chk("rtEmpty", empty_flag_n, 1'b0);
    end
  endtask

  // watchdog
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    complete_run();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    {rstn, master_reset_n, flag_timing_select, readStrobeMode, markIn, writeEnable} = '0;
    {partial_reset_n, offset_load_n, retransmit_n} = '1;
    {readEnableN, read_chip_select_n, outputEnableN} = '0;
    outWidthSelect = 2'(OUT_X72);
    writeData = '0;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'hace2_764b));
    read_controller_model_inst.serial_idle();
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    mreset(1'b0, 2'(OUT_X72));
    chk("resetData", read_data_out, '0);
    chkFlags();
    // serial offsets, then read back through the offset path
    eOfs = $urandom_range(8, 1);
    fOfs = $urandom_range(8, 1);
    read_controller_model_inst.load_serial({18'(eOfs), 18'(fOfs)});
    repeat (8) @(negedge clock);
    offset_load_n = 1'b0;
    read_controller_model_inst.read_pulse();
    chk("emptyOfs", read_data_out, DATA_W'(eOfs));
    read_controller_model_inst.read_pulse();
    chk("fullOfs", read_data_out, DATA_W'(fOfs));
    offset_load_n = 1'b1;
    // fill past full, one refused write at the end
    for (int i = 0; i <= DEP; i++) wr(rnd());
    repeat (3) rd();
    ctlPulse(1'b1, 1'b0);
    repeat (2) rd();
    ctlPulse(1'b0, 1'b1);
    rd();
    // chip select high: read ignored, outputs released
    read_chip_select_n = 1'b1;
    read_controller_model_inst.read_pulse();
    chk("csDriveOff", readDataOutEnable, 1'b0);
    chk("csHeldData", read_data_out, lastOut);
    read_chip_select_n = 1'b0;
    rd();
    chk("csDriveOn", readDataOutEnable, 1'b1);
    readStrobeMode = 1'b1;
    repeat (2) rd();
    readStrobeMode = 1'b0;
    // partial reset with chip select high and output enable low
    read_chip_select_n = 1'b1;
    partial_reset_n = 1'b0;
    repeat (6) @(negedge clock);
    chk("resetDrive", readDataOutEnable, 1'b1);
    partial_reset_n = 1'b1;
    read_chip_select_n = 1'b0;
    repeat (6) @(negedge clock);
    wrP = 0;
    rdP = 0;
    markP = 0;
    lastOut = '0;
    chk("prsData", read_data_out, '0);
    chkFlags();
    repeat (eOfs + 1) wr(rnd());
    rd();
    // narrow bus with synchronous flags
    mreset(1'b1, 2'(OUT_X36));
    w = rnd();
    wr(w);
    read_controller_model_inst.read_pulse();
    rdP = 1;
    chk("x36Low", read_data_out, {36'h0_0000_0000, w[35:0]});
    read_controller_model_inst.read_pulse();
    chk("x36High", read_data_out, {36'h0_0000_0000, w[71:36]});
    chkFlags();
    complete_run();
  end
endmodule
